//--- bench/acw_ctrl_monitor.sv
// assertions on the control register write path
`timescale 1ns/1ns
module acw_ctrl_monitor (input wire mclk, rst_n, transmit_frame_sync_n,
  input wire hardware_convert_pin, conversion_start_bit, standby_bit,
  input wire power_down, settle_active, convert_start,
  input wire [2:0] channel_select);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reset_zero_a: assert property ($rose(rst_n) |-> !{channel_select,
    conversion_start_bit, standby_bit, power_down}) else $error("reset");
  idle_hold_a: assert property (transmit_frame_sync_n [*8] |->
    $stable({channel_select, conversion_start_bit})) else $error("idle");
  pulse_one_a: assert property (convert_start |=> !convert_start)
    else $error("pulse");
  settle_then_a: assert property ($rose(settle_active) |->
    settle_active [*4] ##[0:1] convert_start) else $error("settle");
  conversion_start_bit_trig_a: assert property ($rose(conversion_start_bit) |->
    ##[0:3] settle_active) else $error("conversion_start_bit");
  pin_trig_a: assert property ($fell(hardware_convert_pin) &&
    !conversion_start_bit && !power_down && !settle_active |->
    ##[1:6] settle_active) else $error("pin");
  pd_enter_a: assert property ($rose(power_down) |-> standby_bit)
    else $error("enter");
  pd_leave_a: assert property ($fell(standby_bit) |->
    ##[0:2] !power_down) else $error("leave");
  cover property (convert_start);
  cover property (power_down);
  cover property (settle_active && !conversion_start_bit);
endmodule
bind acw_ctrl_write acw_ctrl_monitor acw_ctrl_monitor_i (.*);

//--- bench/acw_host.sv
// host serial port model for control writes
`timescale 1ns/1ns
module acw_host (output reg transmit_frame_sync_n = 1,
  output reg sclk = 1, sdata_in = 0);
  task send(input [4:0] v, input int n);
    transmit_frame_sync_n = 0;
    for (int i = 0; i < n; i++) begin
      sdata_in = i < 5 ? v[4 - i] : ~sdata_in;
      #80 sclk = 0;
      #80 sclk = 1;
    end
    #80 transmit_frame_sync_n = 1;
    sdata_in = ~sdata_in;
    #300;
  endtask
endmodule

//--- bench/testbench.sv
// bench for the control register write path
`timescale 1ns/1ns
module testbench;
  reg   mclk = 0, rst_n = 0, hardware_convert_pin = 1;
  int   mismatches = 0, tests_run = 0, pulses = 0;
  wire  transmit_frame_sync_n, sclk, sdata_in, standby_bit, power_down;
  wire  conversion_start_bit, settle_active, convert_start;
  wire  [2:0] channel_select;
  wire  [5:0] st = {channel_select, conversion_start_bit, standby_bit,
    power_down};
  // value, falling edges, state expected; a short frame must change nothing
  // standby written with only six edges must not yet power down
  logic [14:0] frames [6] = '{{5'h14, 4'h6, 6'h28}, {5'h08, 4'h5, 6'h28},
    {5'h08, 4'h6, 6'h10}, {5'h01, 4'h6, 6'h02}, {5'h01, 4'h7, 6'h03},
    {5'h00, 4'h6, 6'h00}};
  acw_host acw_host_i (.*);
  acw_ctrl_write #(.SETTLE_CYC(4)) acw_ctrl_write_i (.*);
  initial forever #5 mclk = ~mclk;
  always @(negedge mclk) if (convert_start === 1'b1) pulses <= pulses + 1;
  task check(input [39:0] w, input [5:0] s, e);
    tests_run++;
    if (s !== e) $display("CHECK FAILED %0s exp %h seen %h", w, e, s);
    if (s !== e) mismatches++;
  endtask
  task finish_test;
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task pin; hardware_convert_pin = 0; #40 hardware_convert_pin = 1; endtask
  task t_regs;
    check("reset", st, 6'h00);
    foreach (frames[i]) begin
      acw_host_i.send(frames[i][14:10], frames[i][9:6]);
      check("frame", st, frames[i][5:0]);
    end
  endtask
  task t_conversion_start_bit;
    pin;
    acw_host_i.send(5'h0A, 6);
    pin;
    acw_host_i.send(5'h0A, 3);
    check("conversion_start_bit", pulses[5:0], 6'h03);
    acw_host_i.send(5'h08, 6);
    pulses = 0;
    pin;
    #300 check("pin", pulses[5:0], 6'h01);
  endtask
  initial begin #40 rst_n = 1; #30 t_regs; t_conversion_start_bit; finish_test; end
  initial #60000 begin mismatches++; finish_test; end
endmodule

//--- rtl/acw_ctrl_write.v
// serial write path into the converter control register
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - five-bit control register: channel select, conversion start, standby.
// - frame ending before six clocks leaves the register unchanged.
// - a full frame that writes conversion start set, or a short frame while it is set, triggers a conversion except while powered down.
// - all control bits are zero after power-on reset.
// - standby takes effect on the seventh falling clock; zero wakes.
// - conversion start bit set masks the hardware convert pin.
// - write trigger or convert pin launches settle pulse; conversion starts when it ends.
//////////////////////////////////////////////////////////////////////////////
`include "acw_regs.vh"

module acw_ctrl_write #(
  parameter SETTLE_CYC = `ACW_SETTLE_CYC
) (
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // serial link from host
  input  wire       transmit_frame_sync_n,
  input  wire       sclk,
  input  wire       sdata_in,
  // hardware trigger
  input  wire       hardware_convert_pin,
  // register view and converter control
  output reg  [2:0] channel_select,
  output reg        conversion_start_bit,
  output reg        standby_bit,
  output reg        power_down,
  output reg        settle_active,
  output reg        convert_start
);

  //////////////////////////////////////////////////////////////////////////
  // local constants
  localparam [3:0]  LOAD_IDX    = `ACW_LOAD_EDGES - 4'h1;
  localparam [3:0]  STANDBY_BIT_IDX    = `ACW_STANDBY_BIT_EDGES - 4'h1;
  localparam [3:0]  CNT_MAX     = 4'hF;
  localparam [15:0] SETTLE_LOAD = SETTLE_CYC[15:0];
  localparam [15:0] SETTLE_ONE  = 16'h0001;
  localparam        NUM_SYNC    = 4;
  // settle sequencer states
  localparam [1:0]  SET_IDLE    = 2'b00;
  localparam [1:0]  SET_WAIT    = 2'b01;
  localparam [1:0]  SET_FIRE    = 2'b10;

  //////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage feeds only the second
  wire [3:0] pin_raw = {hardware_convert_pin, sdata_in, sclk,
                        transmit_frame_sync_n};
  wire [3:0] pin_sync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      // pins idle high, so a released reset does not fake an edge
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_sync[gi] = s2_q;
    end
  endgenerate

  wire fs_low = ~pin_sync[0];
  wire sclk_s = pin_sync[1];
  wire sdi    = pin_sync[2];
  wire cnv_s  = pin_sync[3];

  //////////////////////////////////////////////////////////////////////////
  // edge detection on the synchronised pins
  reg sclk_d1_q;
  reg cnv_d1_q;
  reg fs_low_d1_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d1_q   <= 1'b1;
      cnv_d1_q    <= 1'b1;
      fs_low_d1_q <= 1'b0;
    end else begin
      sclk_d1_q   <= sclk_s;
      cnv_d1_q    <= cnv_s;
      fs_low_d1_q <= fs_low;
    end
  end

  wire sclk_fall = sclk_d1_q & ~sclk_s;
  wire hw_fall   = cnv_d1_q & ~cnv_s;
  wire frame_end = fs_low_d1_q & ~fs_low;

  //////////////////////////////////////////////////////////////////////////
  // falling edge counter within a frame
  reg  [3:0] cnt_q;
  wire       edge_in  = fs_low & sclk_fall;
  wire       shift_en = edge_in & (cnt_q < LOAD_IDX);
  wire       at_load  = edge_in & (cnt_q == LOAD_IDX);
  wire       at_standby_bit  = edge_in & (cnt_q == STANDBY_BIT_IDX);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (!fs_low) begin
      cnt_q <= 4'h0;
    end else if (edge_in && cnt_q != CNT_MAX) begin
      // saturate so a long frame never wraps into a second load
      cnt_q <= cnt_q + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial shift, msb first
  reg [4:0] shift_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 5'h00;
    end else if (shift_en) begin
      shift_q <= {shift_q[3:0], sdi};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register: all five bits commit together at the sixth edge,
  // so a frame cut short leaves every bit as it was
  reg [4:0] ctrl_q;
  reg       loaded_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ACW_CTRL_RESET;
    end else if (at_load) begin
      ctrl_q <= shift_q;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q <= 1'b0;
    end else if (!fs_low) begin
      loaded_q <= 1'b0;
    end else if (at_load) begin
      loaded_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion trigger from a write frame
  reg  trig_q;
  wire trig_full  = at_load & shift_q[`ACW_BIT_CONVERSION_START_BIT];
  // a frame cut short still converts when conversion start is set
  wire trig_short = frame_end & ~loaded_q & ctrl_q[`ACW_BIT_CONVERSION_START_BIT];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_full | trig_short;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // standby: zero wakes at the commit, one sleeps only at the seventh edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_down <= 1'b0;
    end else if (at_load && !shift_q[`ACW_BIT_STANDBY_BIT]) begin
      power_down <= 1'b0;
    end else if (at_standby_bit) begin
      power_down <= ctrl_q[`ACW_BIT_STANDBY_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settle sequencer: the settle pulse runs first, then conversion starts
  reg  [1:0]  set_state_q;
  reg  [1:0]  set_state_d;
  reg  [15:0] settle_cnt_q;
  reg  [15:0] settle_cnt_d;
  // the pin is masked while conversion start is set; nothing starts asleep
  wire        pin_req   = hw_fall & ~ctrl_q[`ACW_BIT_CONVERSION_START_BIT];
  wire        start_req = (trig_q | pin_req) & ~power_down;

  always @* begin
    set_state_d  = set_state_q;
    settle_cnt_d = settle_cnt_q;
    case (set_state_q)
      SET_IDLE: begin
        set_state_d = SET_IDLE;
      end
      SET_WAIT: begin
        if (settle_cnt_q <= SETTLE_ONE) begin
          set_state_d = SET_FIRE;
        end else begin
          settle_cnt_d = settle_cnt_q - SETTLE_ONE;
        end
      end
      SET_FIRE: begin
        set_state_d = SET_IDLE;
      end
      default: begin
        set_state_d = SET_IDLE;
      end
    endcase
    // a new request restarts the settle time from the top
    if (start_req) begin
      set_state_d  = SET_WAIT;
      settle_cnt_d = SETTLE_LOAD;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      set_state_q   <= SET_IDLE;
      settle_cnt_q  <= 16'h0000;
      settle_active <= 1'b0;
      convert_start <= 1'b0;
    end else begin
      set_state_q   <= set_state_d;
      settle_cnt_q  <= settle_cnt_d;
      settle_active <= (set_state_d == SET_WAIT);
      convert_start <= (set_state_d == SET_FIRE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register view
  always @* begin
    channel_select       = ctrl_q[`ACW_BIT_CH_MSB:`ACW_BIT_CH_LSB];
    conversion_start_bit = ctrl_q[`ACW_BIT_CONVERSION_START_BIT];
    standby_bit          = ctrl_q[`ACW_BIT_STANDBY_BIT];
  end

endmodule

//--- rtl/acw_regs.vh
// constants for the serial control register write path
`ifndef ACW_REGS_VH
`define ACW_REGS_VH
`define ACW_CTRL_WIDTH      5
`define ACW_CTRL_RESET      5'h00
`define ACW_BIT_CH_MSB      4
`define ACW_BIT_CH_LSB      2
`define ACW_BIT_CONVERSION_START_BIT        1
`define ACW_BIT_STANDBY_BIT        0
`define ACW_LOAD_EDGES      4'h6
`define ACW_STANDBY_BIT_EDGES      4'h7
`define ACW_SETTLE_NS       2000
`define ACW_CLK_NS          10
`define ACW_SETTLE_CYC      ((`ACW_SETTLE_NS + `ACW_CLK_NS - 1) / `ACW_CLK_NS)
`endif
